// >>> rtl/float_norm_pkg.sv
package float_norm_pkg;

    // ************************************************************
    // Word layout, bit index 35 is the sign
    // ************************************************************
    localparam int WORD_W = 36;
    localparam int CNT_W = 9;
    localparam int DLY_W = 4;
    localparam int ACC_SIGN = 35;
    localparam int ACC_FRAC_MSB = 26;
    localparam int QUO_SIGN = 35;
    localparam int QUO_ZERO_BIT = 34;
    localparam int EXP_HI = 34;
    localparam int EXP_LO = 27;
    localparam int CNT_SIGN = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
    localparam logic [DLY_W-1:0] DLY_RESET = 4'h0;

    // ************************************************************
    // Timing: settle delays are least times and round up
    // ************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SETTLE_TIME_NS = 20;
    localparam int LOOP_DELAY_NS = 4;
    localparam int SETTLE_CYC_RAW = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOOP_CYC_RAW = (LOOP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [DLY_W-1:0] SETTLE_CYCLES = DLY_W'((SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW);
    localparam logic [DLY_W-1:0] LOOP_CYCLES = DLY_W'((LOOP_CYC_RAW < 1) ? 1 : LOOP_CYC_RAW);

    // ************************************************************
    // Sequencer steps
    // ************************************************************
    typedef enum logic [11:0] {
        ST_IDLE       = 12'h001,
        ST_SETUP      = 12'h002,
        ST_RSHIFT     = 12'h004,
        ST_ZERO_TEST  = 12'h008,
        ST_NEGATE_EXP = 12'h010,
        ST_LOOP       = 12'h020,
        ST_LOOP_WAIT  = 12'h040,
        ST_EXP_CHECK  = 12'h080,
        ST_ROUND      = 12'h100,
        ST_FINAL      = 12'h200,
        ST_SETTLE_MUL = 12'h400,
        ST_SETTLE_DIV = 12'h800
    } norm_state_t;

endpackage : float_norm_pkg

// >>> rtl/norm_detect.sv
`timescale 1ns/1ps
module norm_detect
    import float_norm_pkg::*;
(
    input wire logic [float_norm_pkg::WORD_W-1:0] acc_in, // Accumulator
    input wire logic [float_norm_pkg::WORD_W-1:0] quo_in, // Quotient register
    output logic normalized_out, // Fraction is normalized
    output logic zero_out // Result is zero
);
    wire msb_differs;
    wire half_mag;
    assign msb_differs = acc_in[ACC_FRAC_MSB] != acc_in[ACC_SIGN];
    // Both +1/2 and -1/2 show a lone one at the fraction head
    assign half_mag = acc_in[ACC_FRAC_MSB] && (acc_in[ACC_FRAC_MSB-1:0] == '0);
    assign normalized_out = msb_differs || half_mag;
    // The lower rounding bit of a quotient never takes part
    assign zero_out = (acc_in == '0) && !quo_in[QUO_ZERO_BIT];
endmodule : norm_detect

// >>> rtl/float_normalize_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Normalized when fraction head differs from sign, or magnitude is exactly one half.
// - Add enters at setup; every fraction instruction finishes through this normalizer.
// - Setup step sets shift enable, linking accumulator and quotient into one shifter.
// - Next step increments the positive exponent and right shifts the register pair.
// - Zero when accumulator is zero and quotient bit one is zero; then skip to final.
// - Nonzero result complements the step counter, then enters the normalizing loop unless already normalized.
// - Zero test for divide still looks only at quotient bit one.
// - While not normalized, each loop step increments exponent and left shifts the pair.
// - Loop retriggers itself through a delay until normalized, then checks exponent.
// - Positive step counter at exponent check sets the overflow flag.
// - Positive result at exponent check complements the step counter.
module float_normalize_sequencer
    import float_norm_pkg::*;
(
    input wire logic ref_clk_in, // Clock
    input wire logic rst_in, // Synchronous reset
    input wire logic load_in, // Load operand registers while idle
    input wire logic [float_norm_pkg::WORD_W-1:0] acc_load_in, // Accumulator load value
    input wire logic [float_norm_pkg::WORD_W-1:0] quo_load_in, // Quotient load value
    input wire logic [float_norm_pkg::CNT_W-1:0] cnt_load_in, // Step counter load value
    input wire logic [float_norm_pkg::CNT_W-1:0] exponent_in, // Exponent register contents
    input wire logic fadd_last_step_in, // Add finished
    input wire logic fmul_last_step_in, // Multiply finished
    input wire logic fdiv_return_step_in, // Divide subroutine returned
    input wire logic fdiv_extra_shift_step_in, // Divide extra shift step
    input wire logic clear_overflow_in, // Clear overflow flag
    output logic [float_norm_pkg::WORD_W-1:0] accumulator_out, // Accumulator
    output logic [float_norm_pkg::WORD_W-1:0] quotient_out, // Quotient register
    output logic [float_norm_pkg::CNT_W-1:0] step_counter_out, // Step counter
    output logic shift_enable_out, // Shift enable flag
    output logic overflow_out, // Arithmetic overflow flag
    output logic busy_out, // Normalizer running
    output logic done_out // Final step pulse
);

    // ************************************************************
    // Registers and decode
    // ************************************************************
    norm_state_t state;
    norm_state_t next_state;
    logic [WORD_W-1:0] accumulator_reg;
    logic [WORD_W-1:0] quotient_reg;
    logic [CNT_W-1:0] step_counter;
    logic shift_enable_flag;
    logic zero_seen;
    logic [DLY_W-1:0] delay_count;
    wire normalized;
    wire zero_result;
    wire link_right;
    wire link_left;
    wire [WORD_W-1:0] shr_acc;
    wire [WORD_W-1:0] shr_quo;
    wire [WORD_W-1:0] shl_acc;
    wire [WORD_W-1:0] shl_quo;
    wire [CNT_W-1:0] cnt_inc;
    wire [CNT_W-1:0] cnt_not;
    wire cnt_positive;
    wire idle;
    wire delay_done;
    wire set_overflow;

    norm_detect u_detect (
        .acc_in(accumulator_reg),
        .quo_in(quotient_reg),
        .normalized_out(normalized),
        .zero_out(zero_result)
    );

    // The flag joins the two registers at their facing ends; without it the
    // ends take zeros so a stray shift cannot leak bits between them.
    assign link_right = shift_enable_flag ? accumulator_reg[0] : 1'b0;
    assign link_left = shift_enable_flag ? quotient_reg[QUO_ZERO_BIT] : 1'b0;
    assign shr_acc = {accumulator_reg[ACC_SIGN], accumulator_reg[WORD_W-1:1]};
    assign shr_quo = {quotient_reg[QUO_SIGN], link_right, quotient_reg[QUO_ZERO_BIT:1]};
    assign shl_acc = {accumulator_reg[ACC_SIGN], accumulator_reg[WORD_W-3:0], link_left};
    assign shl_quo = {quotient_reg[QUO_SIGN], quotient_reg[WORD_W-3:0], 1'b0};
    assign cnt_inc = step_counter + 9'h001;
    assign cnt_not = ~step_counter;
    assign cnt_positive = !step_counter[CNT_SIGN];
    assign idle = state == ST_IDLE;
    assign delay_done = delay_count == DLY_RESET;
    assign set_overflow = (state == ST_EXP_CHECK) && cnt_positive;

    // ************************************************************
    // Step sequencing
    // ************************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (fadd_last_step_in)
                    next_state = ST_SETUP;
                else if (fmul_last_step_in)
                    next_state = ST_SETTLE_MUL;
                else if (fdiv_extra_shift_step_in)
                    next_state = ST_SETTLE_DIV;
            end
            ST_SETUP: next_state = ST_RSHIFT;
            ST_RSHIFT: next_state = ST_ZERO_TEST;
            ST_ZERO_TEST: next_state = zero_result ? ST_FINAL : ST_NEGATE_EXP;
            ST_NEGATE_EXP: next_state = normalized ? ST_EXP_CHECK : ST_LOOP;
            ST_LOOP: next_state = ST_LOOP_WAIT;
            ST_LOOP_WAIT:
            begin
                if (delay_done)
                    next_state = normalized ? ST_EXP_CHECK : ST_LOOP;
            end
            ST_EXP_CHECK: next_state = ST_ROUND;
            ST_ROUND: next_state = ST_FINAL;
            ST_FINAL: next_state = ST_IDLE;
            ST_SETTLE_MUL: next_state = delay_done ? ST_ZERO_TEST : ST_SETTLE_MUL;
            ST_SETTLE_DIV: next_state = delay_done ? ST_SETUP : ST_SETTLE_DIV;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Settle and loop delays share one down counter, loaded on entry
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            delay_count <= DLY_RESET;
        else if (next_state == ST_LOOP_WAIT && state != ST_LOOP_WAIT)
            delay_count <= LOOP_CYCLES - 4'h1;
        else if ((next_state == ST_SETTLE_MUL || next_state == ST_SETTLE_DIV) && idle)
            delay_count <= SETTLE_CYCLES - 4'h1;
        else if (!delay_done)
            delay_count <= delay_count - 4'h1;
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            accumulator_reg <= WORD_RESET;
            quotient_reg <= WORD_RESET;
            step_counter <= CNT_RESET;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (load_in)
                    begin
                        accumulator_reg <= acc_load_in;
                        quotient_reg <= quo_load_in;
                        step_counter <= cnt_load_in;
                    end
                    else if (fdiv_return_step_in)
                        step_counter <= exponent_in;
                    else if (fdiv_extra_shift_step_in)
                    begin
                        accumulator_reg <= shr_acc;
                        quotient_reg <= shr_quo;
                    end
                end
                ST_RSHIFT:
                begin
                    step_counter <= cnt_inc;
                    accumulator_reg <= shr_acc;
                    quotient_reg <= shr_quo;
                end
                ST_NEGATE_EXP: step_counter <= cnt_not;
                ST_LOOP:
                begin
                    step_counter <= cnt_inc;
                    accumulator_reg <= shl_acc;
                    quotient_reg <= shl_quo;
                end
                ST_EXP_CHECK:
                begin
                    if (!accumulator_reg[ACC_SIGN])
                        step_counter <= cnt_not;
                end
                ST_FINAL:
                begin
                    // A zero result keeps its cleared exponent field
                    if (!zero_seen)
                        accumulator_reg[EXP_HI:EXP_LO] <= step_counter[EXP_HI-EXP_LO:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            shift_enable_flag <= 1'b0;
        else if (state == ST_SETUP || (idle && (fmul_last_step_in || fdiv_return_step_in)))
            shift_enable_flag <= 1'b1;
        else if (state == ST_FINAL)
            shift_enable_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            zero_seen <= 1'b0;
        else if (state == ST_ZERO_TEST)
            zero_seen <= zero_result;
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            overflow_out <= 1'b0;
        else if (set_overflow)
            overflow_out <= 1'b1;
        else if (clear_overflow_in)
            overflow_out <= 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            busy_out <= next_state != ST_IDLE;
            done_out <= next_state == ST_FINAL;
        end
    end

    assign accumulator_out = accumulator_reg;
    assign quotient_out = quotient_reg;
    assign step_counter_out = step_counter;
    assign shift_enable_out = shift_enable_flag;

    // ************************************************************
    // Checks
    // ************************************************************
    localparam int A_SETTLE_MAX = 16;

    default clocking a_clk @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_mul_wait;
        shift_enable_flag ##[1:A_SETTLE_MAX] (state == ST_ZERO_TEST);
    endsequence

    sequence s_check_tail;
        (state == ST_ROUND) ##1 (state == ST_FINAL) ##1 (state == ST_IDLE);
    endsequence

    a_exit_is_normal: assert property ((state == ST_EXP_CHECK) |-> normalized)
        else $error("exponent check reached with unnormalized fraction");
    a_fadd_entry: assert property (idle && fadd_last_step_in |=> state == ST_SETUP ##1
        state == ST_RSHIFT)
        else $error("add did not enter normalizer at setup");
    a_setup_flag: assert property ((state == ST_SETUP) |=> shift_enable_flag [*2])
        else $error("setup did not set shift enable");
    a_rshift_step: assert property ((state == ST_RSHIFT) |=> step_counter == $past(cnt_inc)
        && accumulator_reg[ACC_SIGN] == $past(accumulator_reg[ACC_SIGN])
        && accumulator_reg[WORD_W-2:0] == $past(accumulator_reg[WORD_W-1:1]))
        else $error("right shift step wrong");
    a_zero_skip: assert property ((state == ST_ZERO_TEST) && accumulator_reg == '0
        && !quotient_reg[QUO_ZERO_BIT] |=> state == ST_FINAL)
        else $error("zero result did not skip to final");
    a_low_bit_ignored: assert property ((state == ST_ZERO_TEST) && accumulator_reg == '0
        && !quotient_reg[QUO_ZERO_BIT] && quotient_reg[QUO_ZERO_BIT-1]
        |=> state == ST_FINAL)
        else $error("rounding bit affected zero test");
    a_negate_exp: assert property ((state == ST_ZERO_TEST) && !zero_result
        |=> state == ST_NEGATE_EXP ##1 step_counter == ~$past(step_counter))
        else $error("nonzero result did not complement exponent");
    a_mul_entry: assert property (idle && fmul_last_step_in && !fadd_last_step_in
        |=> s_mul_wait)
        else $error("multiply entry did not reach zero test");
    a_div_entry: assert property (idle && fdiv_extra_shift_step_in && !fadd_last_step_in
        && !fmul_last_step_in |=> ##[1:A_SETTLE_MAX] (state == ST_SETUP))
        else $error("divide entry did not reach setup");
    a_loop_shift: assert property ((state == ST_LOOP) |=> step_counter == $past(cnt_inc)
        && accumulator_reg[WORD_W-2:1] == $past(accumulator_reg[WORD_W-3:0]))
        else $error("loop step did not count and shift left");
    a_loop_retrig: assert property ((state == ST_LOOP_WAIT) && delay_done && !normalized
        |=> state == ST_LOOP)
        else $error("loop did not retrigger");
    a_overflow_set: assert property ((state == ST_EXP_CHECK) && !step_counter[CNT_SIGN]
        |=> overflow_out [*2])
        else $error("positive exponent did not set overflow");
    a_pos_complement: assert property ((state == ST_EXP_CHECK) && !accumulator_reg[ACC_SIGN]
        |=> step_counter == ~$past(step_counter))
        else $error("positive result exponent not complemented");
    a_check_tail: assert property ((state == ST_EXP_CHECK) |=> s_check_tail)
        else $error("exponent check did not round then finish");

endmodule : float_normalize_sequencer

// >>> dv/fp_seq_model.sv
`timescale 1ns/1ps
// ************************************************************
// Add, multiply and divide sequencers that call the normalizer
// ************************************************************
module fp_seq_model
(
    input wire logic ref_clk_in, // Clock
    input wire logic rst_in, // Synchronous reset
    input wire logic cmd_in, // Finish one operation
    input wire logic [1:0] op_in, // 0 add, 1 multiply, 2 divide
    output logic fadd_out, // Add last step
    output logic fmul_out, // Multiply last step
    output logic fdiv_ret_out, // Divide return step
    output logic fdiv_shift_out // Divide extra shift step
);
    logic [1:0] div_wait;
    logic div_go;

    assign div_go = cmd_in && (op_in == 2'h2);

    // Divide spaces its two steps so the exponent copy lands before the shift
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            fadd_out <= 1'b0;
            fmul_out <= 1'b0;
            fdiv_ret_out <= 1'b0;
            fdiv_shift_out <= 1'b0;
            div_wait <= 2'h0;
        end
        else
        begin
            fadd_out <= cmd_in && (op_in == 2'h0);
            fmul_out <= cmd_in && (op_in == 2'h1);
            fdiv_ret_out <= div_go;
            div_wait <= div_go ? 2'h2 : ((div_wait != 2'h0) ? div_wait - 2'h1 : 2'h0);
            fdiv_shift_out <= (div_wait == 2'h1);
        end
    end
endmodule : fp_seq_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    import float_norm_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [WORD_W-1:0] acc;
        logic [WORD_W-1:0] quo;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] expo;
        logic [WORD_W-1:0] exp_acc;
        logic [WORD_W-1:0] exp_quo;
        logic [CNT_W-1:0] exp_cnt;
        logic exp_ovf;
    } row_t;
    logic ref_clk, rst, load, clr_ovf, cmd;
    logic [1:0] op;
    logic [WORD_W-1:0] acc_load, quo_load, acc, quo;
    logic [CNT_W-1:0] cnt_load, expo, cnt;
    logic fadd, fmul, fdiv_ret, fdiv_shift, sh_en, ovf, busy, done;
    int num_errors = 0;
    int total_checks = 0;
    // ************************************************************
    // Cases: op, acc, quo, counter, exponent, then expected results
    // ************************************************************
    row_t rows [9] = '{
        '{2'h0, 36'h0, 36'h0, 9'h080, 9'h000, 36'h0, 36'h0, 9'h081, 1'b0},
        '{2'h0, 36'h0_0800_0000, 36'h0, 9'h080, 9'h000, 36'h4_0c00_0000, 36'h0, 9'h081, 1'b0},
        '{2'h0, 36'h0_0040_0000, 36'h0, 9'h080, 9'h000, 36'h3_e400_0000, 36'h0, 9'h07c, 1'b0},
        '{2'h0, 36'h0_0000_0001, 36'h0, 9'h0a0, 9'h000, 36'h4_3400_0000, 36'h0, 9'h086, 1'b0},
        '{2'h0, 36'h0_0800_0000, 36'h0, 9'h0ff, 9'h000, 36'h0_0400_0000, 36'h0, 9'h100, 1'b1},
        '{2'h0, 36'hf_ffe0_0000, 36'h0, 9'h080, 9'h000, 36'hc_2400_0000, 36'h0, 9'h184, 1'b0},
        '{2'h1, 36'h0_0400_0000, 36'h0, 9'h080, 9'h000, 36'h4_0400_0000, 36'h0, 9'h080, 1'b0},
        '{2'h2, 36'h0_0800_0000, 36'h0, 9'h000, 9'h07f, 36'h3_fc00_0000, 36'h0, 9'h07f, 1'b0},
        '{2'h2, 36'h0_0000_0001, 36'h0, 9'h000, 9'h07f, 36'h0, 36'h2_0000_0000, 9'h080, 1'b0}
    };

    float_normalize_sequencer i_float_normalize_sequencer (
        .ref_clk_in(ref_clk), .rst_in(rst), .load_in(load), .acc_load_in(acc_load),
        .quo_load_in(quo_load), .cnt_load_in(cnt_load), .exponent_in(expo),
        .fadd_last_step_in(fadd), .fmul_last_step_in(fmul), .fdiv_return_step_in(fdiv_ret),
        .fdiv_extra_shift_step_in(fdiv_shift), .clear_overflow_in(clr_ovf),
        .accumulator_out(acc), .quotient_out(quo), .step_counter_out(cnt),
        .shift_enable_out(sh_en), .overflow_out(ovf), .busy_out(busy), .done_out(done));
    fp_seq_model i_fp_seq_model (
        .ref_clk_in(ref_clk), .rst_in(rst), .cmd_in(cmd), .op_in(op), .fadd_out(fadd),
        .fmul_out(fmul), .fdiv_ret_out(fdiv_ret), .fdiv_shift_out(fdiv_shift));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Load and clear share a cycle; the start follows so load never meets it
    task automatic start_op(input row_t r);
        @(posedge ref_clk);
        load <= 1'b1;
        clr_ovf <= 1'b1;
        acc_load <= r.acc;
        quo_load <= r.quo;
        cnt_load <= r.cnt;
        expo <= r.expo;
        @(posedge ref_clk);
        load <= 1'b0;
        clr_ovf <= 1'b0;
        cmd <= 1'b1;
        op <= r.op;
        @(posedge ref_clk);
        cmd <= 1'b0;
    endtask : start_op

    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300)
        begin
            num_errors++;
            $display("ERROR at %0t: timeout got %h expected %h", $time, n, 1);
            finish_test();
        end
    endtask : wait_done

    task automatic check_row(input row_t r);
        @(negedge ref_clk);
        check(acc, r.exp_acc);
        check(quo, r.exp_quo);
        check(WORD_W'(cnt), WORD_W'(r.exp_cnt));
        check(WORD_W'({ovf, busy, sh_en, done}), WORD_W'({r.exp_ovf, 3'h0}));
    endtask : check_row

    task automatic check_idle();
        @(negedge ref_clk);
        check(acc | quo, '0);
        check(WORD_W'({cnt, ovf, busy, sh_en, done}), '0);
    endtask : check_idle

    initial
    begin
        int n;
        rst = 1'b1;
        load = 1'b0;
        clr_ovf = 1'b0;
        cmd = 1'b0;
        op = 2'h0;
        acc_load = '0;
        quo_load = '0;
        cnt_load = '0;
        expo = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        check_idle();
        $display("test reset done");
        foreach (rows[i])
        begin
            start_op(rows[i]);
            wait_done(n);
            check_row(rows[i]);
            $display("test row %0d done", i);
        end
        // Zero result skips straight to the final step
        start_op(rows[0]);
        wait_done(n);
        check(WORD_W'(n), WORD_W'(5));
        check_row(rows[0]);
        $display("test zero latency done");
        // Load and a multiply start while busy must leave the add untouched
        start_op(rows[2]);
        repeat (3) @(posedge ref_clk);
        load <= 1'b1;
        acc_load <= '1;
        cmd <= 1'b1;
        op <= 2'h1;
        @(posedge ref_clk);
        load <= 1'b0;
        cmd <= 1'b0;
        @(negedge ref_clk);
        check(WORD_W'({busy, sh_en}), WORD_W'(2'h3));
        wait_done(n);
        check_row(rows[2]);
        $display("test busy refusal done");
        start_op(rows[3]);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        check_idle();
        start_op(rows[3]);
        wait_done(n);
        check_row(rows[3]);
        $display("test mid reset done");
        finish_test();
    end
endmodule : tb
